// *** include/ivfm_map.svh ***
// command codes, field positions, reset values and timing figures
`ifndef IVFM_MAP_SVH
`define IVFM_MAP_SVH

`define IVFM_CMD_OV_FAULT_LIMIT   8'h55
`define IVFM_CMD_OV_FAULT_ACTION  8'h56
`define IVFM_CMD_OV_WARN_LIMIT    8'h57
`define IVFM_CMD_UV_WARN_LIMIT    8'h58
`define IVFM_CMD_UV_FAULT_LIMIT   8'h59

`define IVFM_RST_OV_FAULT_LIMIT   16'h0640
`define IVFM_RST_OV_FAULT_ACTION  8'h84
`define IVFM_RST_OV_WARN_LIMIT    16'h0708
`define IVFM_RST_UV_WARN_LIMIT    16'h0000
`define IVFM_RST_UV_FAULT_LIMIT   16'h0000

`define IVFM_ACT_HI               7
`define IVFM_ACT_LO               6
`define IVFM_RETRY_HI             5
`define IVFM_RETRY_LO             3
`define IVFM_DELAY_HI             2
`define IVFM_DELAY_LO             0

`define IVFM_ACT_CONTINUE         2'h0
`define IVFM_ACT_DISABLE          2'h2
`define IVFM_RETRY_NONE           3'h0
`define IVFM_RETRY_FOREVER        3'h7

`define IVFM_HYST_SHIFT           4
`define IVFM_CLK_KHZ              125000
`define IVFM_RETRY_STEP_MS        25
`define IVFM_RETRY_LONG_MS        175

`endif

// *** include/ivfm_pkg.sv ***
// types for the input voltage fault monitor
package ivfm_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_LATCHED,
    ST_RETRY_WAIT
  } ivfm_state_t;

endpackage

// *** core/ivfm_monitor.sv ***
// input voltage limits, overvoltage fault response and status flags
`timescale 1ns/100ps
`include "ivfm_map.svh"

module ivfm_monitor
  import ivfm_pkg::*;
#(
  parameter int unsigned STEP_CYCLES =
    `IVFM_RETRY_STEP_MS * `IVFM_CLK_KHZ
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // management command port
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output logic             rsp_valid,
  output logic             rsp_err,
  output logic [15:0]      rsp_data,
  // input voltage measurement, 10 mV per count, signed
  input  wire logic        vin_valid,
  input  wire logic [15:0] vin_sample,
  // control and system pins
  input  wire logic        control_pin,
  input  wire logic        bias_ok_pin,
  input  wire logic        operation_on,
  input  wire logic        other_fault,
  input  wire logic        restart,
  input  wire logic        status_clear,
  // outputs
  output logic             output_enable,
  output logic             alert_line_n,
  output logic [3:0]       status_flags
);

  localparam int unsigned LONG_STEPS =
    `IVFM_RETRY_LONG_MS / `IVFM_RETRY_STEP_MS;

  function automatic logic s_gt(input logic [15:0] a, input logic [15:0] b);
    s_gt = $signed(a) > $signed(b);
  endfunction

  logic [15:0] ov_fault_limit_r;
  logic [7:0]  ov_fault_action_r;
  logic [15:0] ov_warn_limit_r;
  logic [15:0] uv_warn_limit_r;
  logic [15:0] uv_fault_limit_r;
  logic [1:0]  ctl_sync_r;
  logic [1:0]  bias_sync_r;
  logic        ov_active_r;
  logic        uv_active_r;
  logic        ov_warn_act_r;
  logic        uv_warn_act_r;
  logic        ov_active_d_r;
  logic [3:0]  status_r;
  logic [31:0] tick_cnt_r;
  logic [2:0]  step_cnt_r;
  ivfm_state_t state_r;
  logic [15:0] ov_clear_lvl;
  logic        run_req;
  logic        bias_ok;
  logic        ov_rise;
  logic [1:0]  act;
  logic [2:0]  retry;
  logic [2:0]  delay;
  logic        wait_done;
  logic [2:0]  delay_steps;

  assign run_req = ctl_sync_r[1] & operation_on;
  assign bias_ok = bias_sync_r[1];
  assign act     = ov_fault_action_r[`IVFM_ACT_HI:`IVFM_ACT_LO];
  assign retry   = ov_fault_action_r[`IVFM_RETRY_HI:`IVFM_RETRY_LO];
  assign delay   = ov_fault_action_r[`IVFM_DELAY_HI:`IVFM_DELAY_LO];
  // 111 is 175 ms, which is exactly seven 25 ms steps
  assign delay_steps = (delay == 3'h7) ? 3'(LONG_STEPS) : delay;
  assign ov_clear_lvl = ov_fault_limit_r -
    (ov_fault_limit_r >> `IVFM_HYST_SHIFT);
  assign ov_rise   = ov_active_r & ~ov_active_d_r;
  assign wait_done = (step_cnt_r == 3'h0) && !ov_active_r;

  // pin synchronisers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_sync_r  <= 2'h0;
      bias_sync_r <= 2'h0;
    end else begin
      ctl_sync_r  <= {ctl_sync_r[0], control_pin};
      bias_sync_r <= {bias_sync_r[0], bias_ok_pin};
    end
  end

  // register writes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ov_fault_limit_r  <= `IVFM_RST_OV_FAULT_LIMIT;
      ov_fault_action_r <= `IVFM_RST_OV_FAULT_ACTION;
      ov_warn_limit_r   <= `IVFM_RST_OV_WARN_LIMIT;
      uv_warn_limit_r   <= `IVFM_RST_UV_WARN_LIMIT;
      uv_fault_limit_r  <= `IVFM_RST_UV_FAULT_LIMIT;
    end else if (cmd_valid && cmd_write) begin
      case (cmd_code)
        `IVFM_CMD_OV_FAULT_LIMIT:  ov_fault_limit_r  <= cmd_wdata;
        `IVFM_CMD_OV_FAULT_ACTION: ov_fault_action_r <= cmd_wdata[7:0];
        `IVFM_CMD_OV_WARN_LIMIT:   ov_warn_limit_r   <= cmd_wdata;
        `IVFM_CMD_UV_WARN_LIMIT:   uv_warn_limit_r   <= cmd_wdata;
        `IVFM_CMD_UV_FAULT_LIMIT:  uv_fault_limit_r  <= cmd_wdata;
        default: ;
      endcase
    end
  end

  // read answer, one cycle after the command
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid <= 1'b0;
      rsp_err   <= 1'b0;
      rsp_data  <= 16'h0000;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_err   <= 1'b0;
      rsp_data  <= 16'h0000;
      if (cmd_valid) begin
        case (cmd_code)
          `IVFM_CMD_OV_FAULT_LIMIT:  rsp_data <= ov_fault_limit_r;
          `IVFM_CMD_OV_FAULT_ACTION: rsp_data <= {8'h00, ov_fault_action_r};
          `IVFM_CMD_OV_WARN_LIMIT:   rsp_data <= ov_warn_limit_r;
          `IVFM_CMD_UV_WARN_LIMIT:   rsp_data <= uv_warn_limit_r;
          `IVFM_CMD_UV_FAULT_LIMIT:  rsp_data <= uv_fault_limit_r;
          default:                   rsp_err  <= 1'b1;
        endcase
      end
    end
  end

  // limit comparisons, evaluated on each new sample
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ov_active_r   <= 1'b0;
      uv_active_r   <= 1'b0;
      ov_warn_act_r <= 1'b0;
      uv_warn_act_r <= 1'b0;
    end else if (vin_valid) begin
      if (s_gt(vin_sample, ov_fault_limit_r))
        ov_active_r <= 1'b1;
      else if (s_gt(ov_clear_lvl, vin_sample))
        ov_active_r <= 1'b0;
      uv_active_r   <= s_gt(uv_fault_limit_r, vin_sample);
      ov_warn_act_r <= s_gt(vin_sample, ov_warn_limit_r);
      uv_warn_act_r <= s_gt(uv_warn_limit_r, vin_sample);
    end
  end

  // sticky status: {uv_warn, ov_warn, uv_fault, ov_fault}; set beats clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r      <= 4'h0;
      ov_active_d_r <= 1'b0;
      status_flags  <= 4'h0;
      alert_line_n  <= 1'b1;
    end else begin
      ov_active_d_r <= ov_active_r;
      status_r <= (status_clear ? 4'h0 : status_r) |
        {uv_warn_act_r, ov_warn_act_r, uv_active_r, ov_active_r};
      status_flags <= status_r;
      alert_line_n <= ~|status_r;
    end
  end

  // retry delay timer: one step per STEP_CYCLES
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_r <= 32'h0;
      step_cnt_r <= 3'h0;
    end else if (state_r != ST_RETRY_WAIT) begin
      tick_cnt_r <= 32'h0;
      step_cnt_r <= delay_steps;
    end else if (step_cnt_r != 3'h0) begin
      if (tick_cnt_r == STEP_CYCLES - 1) begin
        tick_cnt_r <= 32'h0;
        step_cnt_r <= step_cnt_r - 3'h1;
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h1;
      end
    end
  end

  // output state machine
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r       <= ST_IDLE;
      output_enable <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE:
          if (run_req && bias_ok && !other_fault && !ov_active_r)
            state_r <= ST_RUN;
        ST_RUN:
          if (!run_req || !bias_ok || other_fault)
            state_r <= ST_IDLE;
          // unsupported action codes are treated as continue
          else if (ov_rise && act == `IVFM_ACT_DISABLE) begin
            if (retry == `IVFM_RETRY_FOREVER)
              state_r <= ST_RETRY_WAIT;
            else
              state_r <= ST_LATCHED;
          end
        ST_LATCHED:
          if (restart)
            state_r <= ST_IDLE;
        ST_RETRY_WAIT:
          if (!run_req || !bias_ok || other_fault)
            state_r <= ST_IDLE;
          else if (wait_done)
            state_r <= ST_RUN;
        default:
          state_r <= ST_IDLE;
      endcase
      output_enable <= (state_r == ST_RUN) && !(ov_rise &&
        act == `IVFM_ACT_DISABLE);
    end
  end

endmodule // ivfm_monitor

// *** tb/ivfm_checker_monitor.sv ***
// port checker for the input voltage fault monitor
`timescale 1ns/100ps
module ivfm_checker (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // command port
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_code,
  input wire logic        rsp_valid,
  input wire logic        rsp_err,
  input wire logic [15:0] rsp_data,
  // sample, run request and status clear
  input wire logic        vin_valid,
  input wire logic        operation_on,
  input wire logic        status_clear,
  // outputs
  input wire logic        output_enable,
  input wire logic        alert_line_n,
  input wire logic [3:0]  status_flags
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_bad_cmd;
    cmd_valid && (cmd_code < 8'h55 || cmd_code > 8'h59);
  endsequence
  a_rsp_one_later:
    assert property (cmd_valid |=> rsp_valid) else $error("late reply");
  a_rsp_quiet:
    assert property (!cmd_valid |=> !rsp_valid) else $error("stray reply");
  a_err_unmapped:
    assert property (s_bad_cmd |=> rsp_err && rsp_data == 16'h0000)
    else $error("unmapped code accepted");
  a_action_one_byte:
    assert property (cmd_valid && cmd_code == 8'h56 |=>
      rsp_data[15:8] == 8'h00)
    else $error("action reply wider than a byte");
  a_alert_status:
    assert property (alert_line_n == (status_flags == 4'h0))
    else $error("alert and status disagree");
  a_ov_cause:
    assert property ($rose(status_flags[0]) |->
      $past(vin_valid, 3) || $past(vin_valid, 4))
    else $error("fault flag without sample");
  a_clear_only:
    assert property ($fell(status_flags[0]) |->
      $past(status_clear, 2) || $past(status_clear, 3))
    else $error("fault flag lost");
  a_oe_rise:
    assert property ($rose(output_enable) |-> $past(operation_on, 2))
    else $error("output on without request");
endmodule // ivfm_checker

// *** tb/ivfm_host.sv ***
// management host model driving the command port
`timescale 1ns/100ps
module ivfm_host (
  // clock
  input wire logic        sys_clk,
  // request
  output logic            cmd_valid,
  output logic            cmd_write,
  output logic [7:0]      cmd_code,
  output logic [15:0]     cmd_wdata,
  // reply
  input wire logic        rsp_valid,
  input wire logic        rsp_err,
  input wire logic [15:0] rsp_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'hA5A5;
  end
  // one command; the reply stands only in the cycle after the command edge
  task automatic xfer(input logic w, input logic [7:0] c,
    input logic [15:0] d, output logic [15:0] q, output logic e, ok);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = d;
    @(negedge sys_clk);
    ok = rsp_valid;
    e = rsp_err;
    q = rsp_data;
    cmd_valid = 1'b0;
    cmd_wdata = ~d;  // idle data is not left at the last value
  endtask
endmodule // ivfm_host

// *** tb/ivfm_monitor_tb.sv ***
// testbench for the input voltage fault monitor
`timescale 1ns/100ps
module ivfm_monitor_tb;
  logic sys_clk = 1'b0, reset_n = 1'b0, vin_valid = 1'b0;
  logic control_pin = 1'b1, bias_ok_pin = 1'b1, operation_on = 1'b1;
  logic other_fault = 1'b0, restart = 1'b0, status_clear = 1'b0;
  logic [15:0] vin_sample = 16'h0000, q, cmd_wdata, rsp_data;
  logic        cmd_valid, cmd_write, rsp_valid, rsp_err, er, ok;
  logic [7:0]  cmd_code;
  logic        output_enable, alert_line_n;
  logic [3:0]  status_flags;
  int          fail_count = 0;
  int          samples_checked = 0;
  wire [15:0] obs = {10'h000, alert_line_n, output_enable, status_flags};
  always #4 sys_clk = ~sys_clk;
  ivfm_host u_host (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_data(rsp_data));
  // short retry step keeps the delay checks fast
  ivfm_monitor #(.STEP_CYCLES(10)) DUT (.sys_clk(sys_clk),
    .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_err(rsp_err), .rsp_data(rsp_data), .vin_valid(vin_valid),
    .vin_sample(vin_sample), .control_pin(control_pin),
    .bias_ok_pin(bias_ok_pin), .operation_on(operation_on),
    .other_fault(other_fault), .restart(restart),
    .status_clear(status_clear), .output_enable(output_enable),
    .alert_line_n(alert_line_n), .status_flags(status_flags));
  task automatic cmp(input logic [15:0] g, e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] c, input logic [15:0] d);
    u_host.xfer(w, c, d, q, er, ok);
    cmp({15'h0000, ok}, 16'h0001);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    xf(1'b0, c, 16'h0000);
    cmp(q, e);
  endtask
  task automatic smp(input logic [15:0] v);
    @(negedge sys_clk);
    vin_valid = 1'b1;
    vin_sample = v;
    @(negedge sys_clk);
    vin_valid = 1'b0;
    vin_sample = ~v;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic clr;
    @(negedge sys_clk);
    status_clear = 1'b1;
    @(negedge sys_clk);
    status_clear = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic t_regs;
    rd(8'h55, 16'h0640);
    rd(8'h56, 16'h0084);
    rd(8'h57, 16'h0708);
    rd(8'h58, 16'h0000);
    rd(8'h59, 16'h0000);
    u_host.xfer(1'b0, 8'h5A, 16'h0000, q, er, ok);
    cmp({15'h0000, er}, 16'h0001);
    xf(1'b1, 8'h56, 16'hABCD);
    rd(8'h56, 16'h00CD);
    $display("t_regs done");
  endtask
  task automatic t_latch;
    xf(1'b1, 8'h56, 16'h0084);
    smp(16'h0641);
    cmp(obs, 16'h0001);
    smp(16'h0000);
    repeat (20) @(negedge sys_clk);
    cmp(obs, 16'h0001);
    restart = 1'b1;
    @(negedge sys_clk);
    restart = 1'b0;
    repeat (6) @(negedge sys_clk);
    cmp(obs, 16'h0011);
    clr;
    cmp(obs, 16'h0030);
    $display("t_latch done");
  endtask
  task automatic t_retry;
    xf(1'b1, 8'h56, 16'h00BA);
    smp(16'h0641);
    cmp(obs, 16'h0001);
    smp(16'h05DC);
    repeat (30) @(negedge sys_clk);
    cmp(obs, 16'h0001);
    // delay already spent while the fault was held, so restart is quick
    smp(16'h05DB);
    cmp(obs, 16'h0011);
    clr;
    smp(16'h0641);
    smp(16'h05DB);
    // two steps of 10 cycles counted from fault entry, output 22 edges on
    repeat (12) @(negedge sys_clk);
    cmp(obs, 16'h0001);
    @(negedge sys_clk);
    cmp(obs, 16'h0011);
    clr;
    $display("t_retry done");
  endtask
  task automatic t_cont;
    xf(1'b1, 8'h56, 16'h0000);
    xf(1'b1, 8'h59, 16'hFF00);
    xf(1'b1, 8'h58, 16'h0100);
    smp(16'hFE00);
    cmp(obs, 16'h001A);
    smp(16'h0709);
    cmp(obs, 16'h001F);
    xf(1'b1, 8'h59, 16'h0000);
    smp(16'h0500);
    clr;
    cmp(obs, 16'h0030);
    $display("t_cont done");
  endtask
  task automatic t_stop;
    // pin goes off before the fault is lifted, so no restart slips in
    other_fault = 1'b1;
    bias_ok_pin = 1'b0;
    repeat (4) @(negedge sys_clk);
    cmp(obs, 16'h0020);
    other_fault = 1'b0;
    repeat (4) @(negedge sys_clk);
    cmp(obs, 16'h0020);
    bias_ok_pin = 1'b1;
    repeat (6) @(negedge sys_clk);
    cmp(obs, 16'h0030);
    control_pin = 1'b0;
    repeat (4) @(negedge sys_clk);
    cmp(obs, 16'h0020);
    control_pin = 1'b1;
    repeat (6) @(negedge sys_clk);
    cmp(obs, 16'h0030);
    $display("t_stop done");
  endtask
  task results;
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    results;
  end
  initial begin
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    cmp(obs, 16'h0030);
    t_regs;
    t_latch;
    t_retry;
    t_cont;
    t_stop;
    results;
  end
endmodule // ivfm_monitor_tb
bind ivfm_monitor ivfm_checker u_chk (.sys_clk(sys_clk),
  .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
  .cmd_code(cmd_code), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
  .rsp_data(rsp_data), .vin_valid(vin_valid),
  .operation_on(operation_on), .status_clear(status_clear),
  .output_enable(output_enable), .alert_line_n(alert_line_n),
  .status_flags(status_flags));
